// File: include/wpf_pkg.sv
// Wake pattern filter: register map, field positions and shared types
package wpf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte addresses
  localparam logic [7:0] REG_WAKE_CTRL = 8'h68;
  localparam logic [7:0] REG_PATTERN_PORT = 8'h70;
  localparam logic [7:0] REG_INT_STATUS = 8'h90;
  localparam logic [7:0] REG_INT_MASK = 8'h94;
  localparam logic [7:0] REG_POWER_MGMT = 8'h98;
  // Wake control/status fields
  localparam int LINK_CHANGE_BIT = 0;
  localparam int REMOTE_WAKE_BIT = 1;
  localparam int REMOTE_WAKE_EN_BIT = 9;
  localparam int LINK_UP_EN_BIT = 16;
  localparam int LINK_DOWN_EN_BIT = 17;
  localparam int PATTERN1_EN_BIT = 29;
  localparam int CRC_SEED_BIT = 30;
  // Power management register field
  localparam int WAKE_EVENT_BIT = 0;
  // Interrupt status / mask layout
  localparam int INT_W = 3;
  localparam int INT_LINK_BIT = 0;
  localparam int INT_REMOTE_BIT = 1;
  localparam int INT_PATTERN_BIT = 2;
  // Filter table layout
  localparam int PATTERN_COUNT = 5;
  localparam int WORDS_PER_PATTERN = 5;
  localparam int MASK_WORDS = 4;
  localparam int TABLE_WORDS = PATTERN_COUNT * WORDS_PER_PATTERN;
  localparam int PTR_W = 5;
  localparam int MASK_BITS = 128;
  localparam int CRC_LSB = 16;
  localparam int OFFSET_W = 8;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
  localparam logic [15:0] CRC_SEED_ONES = 16'hffff;

  typedef struct packed {
    logic [MASK_BITS-1:0] mask;
    logic [15:0] crc;
    logic [OFFSET_W-1:0] offset;
  } wpf_pattern_t;

  typedef struct packed {
    logic crc_seed;
    logic [PATTERN_COUNT-1:0] pat_en;
    logic link_down_en;
    logic link_up_en;
    logic remote_wake_en;
  } wpf_ctrl_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } wpf_rx_t;
endpackage

// File: src/wpf_pattern_crc.sv
// Wake pattern filter: masked CRC-16 matcher for one stored pattern
`timescale 1ns/10ps
module wpf_pattern_crc
  import wpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pattern and seed selection
  input wire wpf_pattern_t pattern,
  input wire logic seed_ones,
  // Received byte stream
  input wire wpf_rx_t rx,
  // Result
  output logic match
);
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_MAX = 9'h1ff;
  localparam logic [CNT_W-1:0] WIN_LEN = 9'h080;

  logic [15:0] crc;
  logic [CNT_W-1:0] cnt;
  logic [15:0] cur_crc;
  logic [15:0] upd_crc;
  logic [CNT_W-1:0] cur_cnt;
  logic [CNT_W-1:0] idx;
  logic take;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb
  begin
    cur_crc = rx.sof ? (seed_ones ? CRC_SEED_ONES : CRC_SEED_ZERO) : crc;
    cur_cnt = rx.sof ? '0 : cnt;
    idx = cur_cnt - {1'b0, pattern.offset};
    // Byte counted from the start offset, selected by its mask bit
    take = (cur_cnt >= {1'b0, pattern.offset}) && (idx < WIN_LEN)
      && pattern.mask[idx[6:0]];
    upd_crc = take ? crc_byte(cur_crc, rx.data) : cur_crc;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      crc <= CRC_SEED_ZERO;
      cnt <= '0;
    end
    else if (rx.valid)
    begin
      crc <= upd_crc;
      cnt <= (cur_cnt == CNT_MAX) ? CNT_MAX : cur_cnt + 9'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      match <= 1'b0;
    else
      match <= rx.valid && rx.eof && (upd_crc == pattern.crc);
  end
endmodule

// File: src/wpf_wake_filter.sv
// Wake pattern filter: wake flags, filter table port, matchers, interrupts
`timescale 1ns/10ps
module wpf_wake_filter
  import wpf_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic power_on_rst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // Wake events
  input wire logic remote_wake_pkt,
  input wire logic link_up,
  input wire wpf_rx_t rx,
  // Status outputs
  output logic wake_event_status,
  output logic pattern_wake,
  output logic irq
);
  logic [DATA_W-1:0] table_mem [TABLE_WORDS];
  logic [PTR_W-1:0] wr_ptr;
  wpf_ctrl_t ctrl;
  logic link_change_flag;
  logic remote_wake_packet_flag;
  logic next_link_change_flag;
  logic next_remote_wake_packet_flag;
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic link_event;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_event;
  logic [PATTERN_COUNT-1:0] hit;
  logic pattern_event;
  logic [DATA_W-1:0] read_mux;
  logic wr_ctrl;
  logic wr_port;
  logic wr_int_status;
  logic wr_int_mask;
  logic wr_pm;

  assign wr_ctrl = wr_en && (addr == REG_WAKE_CTRL);
  assign wr_port = wr_en && (addr == REG_PATTERN_PORT);
  assign wr_int_status = wr_en && (addr == REG_INT_STATUS);
  assign wr_int_mask = wr_en && (addr == REG_INT_MASK);
  assign wr_pm = wr_en && (addr == REG_POWER_MGMT);

  // Link level comes from the PHY pin, two-stage synchroniser
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
    end
    else
    begin
      link_meta <= link_up;
      link_sync <= link_meta;
      link_prev <= link_sync;
    end
  end

  assign link_event = (link_prev && !link_sync && ctrl.link_down_en)
    || (!link_prev && link_sync && ctrl.link_up_en);

  // Control fields of the wake control/status register
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl <= '0;
    else if (wr_ctrl)
    begin
      ctrl.crc_seed <= wr_data[CRC_SEED_BIT];
      for (int p = 0; p < PATTERN_COUNT; p++)
        ctrl.pat_en[p] <= wr_data[PATTERN1_EN_BIT - p];
      ctrl.link_down_en <= wr_data[LINK_DOWN_EN_BIT];
      ctrl.link_up_en <= wr_data[LINK_UP_EN_BIT];
      ctrl.remote_wake_en <= wr_data[REMOTE_WAKE_EN_BIT];
    end
  end

  // Wake flags: event set beats the one-write clear
  always_comb
  begin
    next_remote_wake_packet_flag = remote_wake_packet_flag;
    next_link_change_flag = link_change_flag;
    if (wr_ctrl && wr_data[REMOTE_WAKE_BIT])
      next_remote_wake_packet_flag = 1'b0;
    if (wr_ctrl && wr_data[LINK_CHANGE_BIT])
      next_link_change_flag = 1'b0;
    if (remote_wake_pkt)
      next_remote_wake_packet_flag = 1'b1;
    if (link_event)
      next_link_change_flag = 1'b1;
  end

  // Only the power-up reset touches the flags
  always_ff @(posedge clk)
  begin
    if (power_on_rst)
    begin
      remote_wake_packet_flag <= 1'b0;
      link_change_flag <= 1'b0;
    end
    else
    begin
      remote_wake_packet_flag <= next_remote_wake_packet_flag;
      link_change_flag <= next_link_change_flag;
    end
  end

  // Filter table: one port, write pointer walks 25 entries and wraps
  always_ff @(posedge clk)
  begin
    if (srst)
      wr_ptr <= '0;
    else if (wr_port)
      wr_ptr <= (wr_ptr == PTR_W'(TABLE_WORDS - 1)) ? '0 : wr_ptr + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < TABLE_WORDS; i++)
        table_mem[i] <= '0;
    end
    else if (wr_port)
      table_mem[wr_ptr] <= wr_data;
  end

  // One matcher per pattern, blocks of five words each
  generate
    for (genvar p = 0; p < PATTERN_COUNT; p++)
    begin : g_pattern
      localparam int BASE = p * WORDS_PER_PATTERN;
      wpf_pattern_t pat;
      assign pat.mask = {table_mem[BASE + 3], table_mem[BASE + 2],
        table_mem[BASE + 1], table_mem[BASE]};
      assign pat.crc = table_mem[BASE + MASK_WORDS][DATA_W-1:CRC_LSB];
      assign pat.offset = table_mem[BASE + MASK_WORDS][OFFSET_W-1:0];
      wpf_pattern_crc u_crc
      (
        .clk(clk),
        .srst(srst),
        .pattern(pat),
        .seed_ones(ctrl.crc_seed),
        .rx(rx),
        .match(hit[p])
      );
    end
  endgenerate

  assign pattern_event = |(hit & ctrl.pat_en);

  always_ff @(posedge clk)
  begin
    if (srst)
      pattern_wake <= 1'b0;
    else
      pattern_wake <= pattern_event;
  end

  // Power management wake event, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (srst)
      wake_event_status <= 1'b0;
    else if (remote_wake_pkt && ctrl.remote_wake_en)
      wake_event_status <= 1'b1;
    else if (wr_pm && wr_data[WAKE_EVENT_BIT])
      wake_event_status <= 1'b0;
  end

  // Interrupt status, mask and level output
  always_comb
  begin
    int_event = '0;
    int_event[INT_LINK_BIT] = link_event;
    int_event[INT_REMOTE_BIT] = remote_wake_pkt;
    int_event[INT_PATTERN_BIT] = pattern_event;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      int_status <= '0;
    else
      int_status <= (int_status & ~(wr_int_status ? wr_data[INT_W-1:0] : '0)) | int_event;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      int_mask <= '0;
    else if (wr_int_mask)
      int_mask <= wr_data[INT_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_mask);
  end

  // Read data; the pattern port and unmapped addresses read zero
  always_comb
  begin
    read_mux = '0;
    case (addr)
      REG_WAKE_CTRL:
      begin
        read_mux[CRC_SEED_BIT] = ctrl.crc_seed;
        for (int p = 0; p < PATTERN_COUNT; p++)
          read_mux[PATTERN1_EN_BIT - p] = ctrl.pat_en[p];
        read_mux[LINK_DOWN_EN_BIT] = ctrl.link_down_en;
        read_mux[LINK_UP_EN_BIT] = ctrl.link_up_en;
        read_mux[REMOTE_WAKE_EN_BIT] = ctrl.remote_wake_en;
        read_mux[REMOTE_WAKE_BIT] = remote_wake_packet_flag;
        read_mux[LINK_CHANGE_BIT] = link_change_flag;
      end
      REG_INT_STATUS: read_mux[INT_W-1:0] = int_status;
      REG_INT_MASK: read_mux[INT_W-1:0] = int_mask;
      REG_POWER_MGMT: read_mux[WAKE_EVENT_BIT] = wake_event_status;
      default: read_mux = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rd_data <= '0;
    else
      rd_data <= rd_en ? read_mux : '0;
  end

  default clocking cb @(posedge clk); endclocking

  sequence s_link_fall;
    link_prev && !link_sync && ctrl.link_down_en;
  endsequence

  sequence s_link_rise;
    !link_prev && link_sync && ctrl.link_up_en;
  endsequence

  a_link_fall_flag: assert property (disable iff (power_on_rst)
    s_link_fall |=> link_change_flag)
    else $error("link fall did not set link change flag");
  a_link_rise_flag: assert property (disable iff (power_on_rst)
    s_link_rise |=> link_change_flag)
    else $error("link rise did not set link change flag");
  a_link_no_enable: assert property (disable iff (power_on_rst || srst)
    !link_change_flag && !ctrl.link_up_en && !ctrl.link_down_en && !wr_ctrl
      |=> !link_change_flag)
    else $error("link flag set with detection disabled");
  a_remote_flag_set: assert property (disable iff (power_on_rst)
    remote_wake_pkt |=> remote_wake_packet_flag)
    else $error("remote packet did not set flag");
  a_flag_one_clear: assert property (disable iff (power_on_rst)
    wr_ctrl && wr_data[REMOTE_WAKE_BIT] && !remote_wake_pkt |=> !remote_wake_packet_flag)
    else $error("write one did not clear remote flag");
  a_flag_zero_keep: assert property (disable iff (power_on_rst)
    wr_ctrl && !wr_data[LINK_CHANGE_BIT] && link_change_flag |=> link_change_flag)
    else $error("write zero cleared link flag");
  a_flag_hw_keep: assert property (disable iff (power_on_rst)
    srst && remote_wake_packet_flag && !wr_ctrl |=> remote_wake_packet_flag)
    else $error("hardware reset cleared remote flag");
  a_flag_por_clear: assert property (
    power_on_rst |=> !remote_wake_packet_flag && !link_change_flag)
    else $error("power-up reset left a flag set");
  a_port_advance: assert property (disable iff (srst)
    wr_port |=> table_mem[$past(wr_ptr)] == $past(wr_data)
      && wr_ptr == ((($past(wr_ptr)) == PTR_W'(TABLE_WORDS - 1)) ? '0 : $past(wr_ptr) + 5'h01))
    else $error("pattern port write went to wrong entry");
  a_wake_event_set: assert property (disable iff (srst)
    remote_wake_pkt && ctrl.remote_wake_en |=> wake_event_status)
    else $error("wake event status not set after remote packet");
  a_wake_event_hold: assert property (disable iff (srst)
    wake_event_status && !(wr_pm && wr_data[WAKE_EVENT_BIT]) |=> wake_event_status)
    else $error("wake event status dropped without a clear");
  a_read_latency: assert property (disable iff (srst || power_on_rst)
    rd_en && addr == REG_WAKE_CTRL |=> rd_data[REMOTE_WAKE_BIT] == $past(remote_wake_packet_flag))
    else $error("read data does not show remote flag");
endmodule

// File: tb/wpf_wake_filter_tb.sv
// Wake pattern filter testbench: registers, wake flags, interrupt and pattern matcher
`timescale 1ns/10ps
module wpf_wake_filter_tb;
  import wpf_pkg::*;
  logic clk;
  logic srst;
  logic power_on_rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic remote_wake_pkt;
  logic link_up;
  wpf_rx_t rx;
  logic wake_event_status;
  logic pattern_wake;
  logic irq;
  int fail_count;
  int checks_done;
  logic [31:0] rv;

  wpf_wake_filter u_wpf_wake_filter (
    .clk(clk),
    .srst(srst),
    .power_on_rst(power_on_rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .remote_wake_pkt(remote_wake_pkt),
    .link_up(link_up),
    .rx(rx),
    .wake_event_status(wake_event_status),
    .pattern_wake(pattern_wake),
    .irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data lands at the edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_remote();
    @(posedge clk);
    remote_wake_pkt <= 1'b1;
    @(posedge clk);
    remote_wake_pkt <= 1'b0;
  endtask

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return r;
  endfunction

  function automatic logic [7:0] frame_byte(input int k);
    return 8'(k * 7 + 3);
  endfunction

  // Sends a frame, then waits a bounded time for a match pulse
  task automatic send_frame(input int len, output logic hit);
    for (int k = 0; k < len; k++)
    begin
      @(posedge clk);
      rx <= '{valid: 1'b1, sof: (k == 0), eof: (k == len - 1), data: frame_byte(k)};
    end
    @(posedge clk);
    rx <= '0;
    hit = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      if (pattern_wake === 1'b1)
        hit = 1'b1;
    end
  endtask

  task automatic scen_reset_values();
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h0000_0000);
    @(posedge clk);
    #1;
    check(rd_data, 32'h0000_0000);
    rd(REG_PATTERN_PORT, rv);
    check(rv, 32'h0000_0000);
    rd(8'h50, rv);
    check(rv, 32'h0000_0000);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0000);
  endtask

  task automatic scen_wake_flags();
    logic [31:0] ctl;
    ctl = (32'h1 << REMOTE_WAKE_EN_BIT) | (32'h1 << LINK_UP_EN_BIT);
    wr(REG_WAKE_CTRL, ctl);
    pulse_remote();
    idle(2);
    check(32'(wake_event_status), 32'h1);
    rd(REG_POWER_MGMT, rv);
    check(rv, 32'h0000_0001);
    wr(REG_POWER_MGMT, 32'h0000_0001);
    idle(1);
    check(32'(wake_event_status), 32'h0);
    rd(REG_WAKE_CTRL, rv);
    check(rv, ctl | 32'h2);
    @(posedge clk);
    link_up <= 1'b1;
    idle(8);
    rd(REG_WAKE_CTRL, rv);
    check(rv, ctl | 32'h3);
    wr(REG_WAKE_CTRL, ctl);
    rd(REG_WAKE_CTRL, rv);
    check(rv, ctl | 32'h3);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h0000_0003);
    wr(REG_WAKE_CTRL, 32'h0000_0001);
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h0000_0002);
    @(posedge clk);
    link_up <= 1'b0;
    idle(8);
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h0000_0002);
    wr(REG_WAKE_CTRL, 32'h1 << LINK_DOWN_EN_BIT);
    @(posedge clk);
    link_up <= 1'b1;
    idle(8);
    rd(REG_WAKE_CTRL, rv);
    check(rv, (32'h1 << LINK_DOWN_EN_BIT) | 32'h2);
    @(posedge clk);
    link_up <= 1'b0;
    idle(8);
    rd(REG_WAKE_CTRL, rv);
    check(rv, (32'h1 << LINK_DOWN_EN_BIT) | 32'h3);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0001);
    @(posedge clk);
    power_on_rst <= 1'b1;
    @(posedge clk);
    power_on_rst <= 1'b0;
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h1 << LINK_DOWN_EN_BIT);
  endtask

  task automatic scen_interrupt();
    pulse_remote();
    idle(2);
    check(32'(irq), 32'h0);
    check(32'(wake_event_status), 32'h0);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0003);
    wr(REG_INT_MASK, 32'h0000_0002);
    idle(2);
    check(32'(irq), 32'h1);
    wr(REG_INT_STATUS, 32'h0000_0002);
    idle(2);
    check(32'(irq), 32'h0);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0001);
    wr(REG_INT_STATUS, 32'h0000_0001);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0000);
    wr(REG_WAKE_CTRL, (32'h1 << LINK_DOWN_EN_BIT) | (32'h1 << REMOTE_WAKE_BIT));
    rd(REG_WAKE_CTRL, rv);
    check(rv, 32'h1 << LINK_DOWN_EN_BIT);
  endtask

  // Pattern 2 selects one byte through mask bit 33, start offset 2
  task automatic scen_pattern();
    logic [15:0] crc;
    logic [31:0] ctl;
    logic hit;
    crc = crc_byte(CRC_SEED_ONES, frame_byte(2 + 33));
    for (int i = 0; i < TABLE_WORDS; i++)
      wr(REG_PATTERN_PORT, (i == 6) ? 32'h0000_0002 : (i == 9) ? {crc, 8'h00, 8'h02} : '0);
    ctl = (32'h1 << CRC_SEED_BIT) | (32'h1 << (PATTERN1_EN_BIT - 1));
    wr(REG_WAKE_CTRL, ctl);
    send_frame(40, hit);
    check(32'(hit), 32'h1);
    rd(REG_INT_STATUS, rv);
    check(rv, 32'h0000_0004);
    wr(REG_WAKE_CTRL, 32'h1 << (PATTERN1_EN_BIT - 1));
    send_frame(40, hit);
    check(32'(hit), 32'h0);
    wr(REG_WAKE_CTRL, (32'h1 << CRC_SEED_BIT) | (32'h1 << PATTERN1_EN_BIT));
    send_frame(40, hit);
    check(32'(hit), 32'h0);
  endtask

  task automatic report_and_stop();
    $display("TB: checks=%0d errors=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    fail_count = 0;
    checks_done = 0;
    srst = 1'b1;
    power_on_rst = 1'b1;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    remote_wake_pkt = 1'b0;
    link_up = 1'b0;
    rx = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    power_on_rst <= 1'b0;
    scen_reset_values();
    scen_wake_flags();
    scen_interrupt();
    scen_pattern();
    report_and_stop();
  end
endmodule
